// [shared/ram_out_pkg.sv]
package ram_out_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int DATA_W = 32;
	localparam int ADDR_W = 10;
	localparam int APB_ADDR_W = 8;
	localparam int NUM_PORTS = 2;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [APB_ADDR_W-1:0] OFF_CFG_A = 8'h00;
	localparam logic [APB_ADDR_W-1:0] OFF_CFG_B = 8'h04;
	localparam logic [APB_ADDR_W-1:0] OFF_INIT_A = 8'h08;
	localparam logic [APB_ADDR_W-1:0] OFF_INIT_B = 8'h0c;
	localparam logic [APB_ADDR_W-1:0] OFF_STATUS = 8'h10;

	// ****************************************
	// configuration fields, one register per port
	// ****************************************
	localparam int CFG_W = 5;
	localparam int CFG_PRIM_BIT = 0;
	localparam int CFG_CORE_BIT = 1;
	localparam int CFG_RSTEN_BIT = 2;
	localparam int CFG_LATCHCLR_BIT = 3;
	localparam int CFG_RSTWIN_BIT = 4;
	localparam logic [CFG_W-1:0] CFG_RESET = 5'h04;
	localparam logic [DATA_W-1:0] INIT_RESET = 32'h0;

	// ****************************************
	// status fields, one byte per port
	// ****************************************
	localparam int STAT_STRIDE = 8;
	localparam int STAT_LAT_LSB = 0;
	localparam int STAT_LATCHCLR_BIT = 2;
	localparam int STAT_REGISTERED_BIT = 3;
	localparam int STAT_USED_W = 4;
	localparam logic [DATA_W-1:0] STATUS_RESET = 32'h0;

endpackage

// [rtl/apb_cfg_regs.sv]
`timescale 1ns/10ps
module apb_cfg_regs (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ram_out_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// register contents
	output logic [ram_out_pkg::CFG_W-1:0] cfgA,
	output logic [ram_out_pkg::CFG_W-1:0] cfgB,
	output logic [ram_out_pkg::DATA_W-1:0] initA,
	output logic [ram_out_pkg::DATA_W-1:0] initB,
	input wire logic [31:0] statusWord
);
	import ram_out_pkg::*;

	logic readyQ;
	logic [31:0] rdataQ;
	logic errQ;
	logic [CFG_W-1:0] cfgAQ;
	logic [CFG_W-1:0] cfgBQ;
	logic [DATA_W-1:0] initAQ;
	logic [DATA_W-1:0] initBQ;
	logic mapped;
	logic [31:0] readMux;
	logic commit;

	// ****************************************
	// decode
	// ****************************************
	always_comb begin
		mapped = 1'b1;
		readMux = 32'h0;
		unique case (paddr)
			OFF_CFG_A: readMux = {{(32-CFG_W){1'b0}}, cfgAQ};
			OFF_CFG_B: readMux = {{(32-CFG_W){1'b0}}, cfgBQ};
			OFF_INIT_A: readMux = initAQ;
			OFF_INIT_B: readMux = initBQ;
			OFF_STATUS: readMux = statusWord;
			default: mapped = 1'b0;
		endcase
	end

	// one wait state: ready rises in the second access cycle
	assign commit = psel & penable & readyQ;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			readyQ <= 1'b0;
			rdataQ <= 32'h0;
			errQ <= 1'b0;
		end else if (psel && penable && !readyQ) begin
			readyQ <= 1'b1;
			rdataQ <= pwrite ? 32'h0 : readMux;
			errQ <= ~mapped;
		end else begin
			readyQ <= 1'b0;
			rdataQ <= 32'h0;
			errQ <= 1'b0;
		end
	end

	// status is read-only; writes to it are dropped quietly
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cfgAQ <= CFG_RESET;
			cfgBQ <= CFG_RESET;
			initAQ <= INIT_RESET;
			initBQ <= INIT_RESET;
		end else if (commit && pwrite) begin
			if (paddr == OFF_CFG_A) cfgAQ <= pwdata[CFG_W-1:0];
			if (paddr == OFF_CFG_B) cfgBQ <= pwdata[CFG_W-1:0];
			if (paddr == OFF_INIT_A) initAQ <= pwdata;
			if (paddr == OFF_INIT_B) initBQ <= pwdata;
		end
	end

	assign prdata = rdataQ;
	assign pready = readyQ;
	assign pslverr = errQ;
	assign cfgA = cfgAQ;
	assign cfgB = cfgBQ;
	assign initA = initAQ;
	assign initB = initBQ;

endmodule

// [rtl/ram_output_register_stage.sv]
// What this block does
// - each port has its own output register configuration, set apart from the other port.
// - choosing the primitive register on a port turns on that port's embedded output register.
// - choosing the core register on a port adds one more register on that port's read data.
// - latch clearing only takes effect with primitive register alone and port reset enabled.
// - with both options, data passes the primitive register and then the core register.
// - reset enabled without latch clearing drives only the output register reset, or the latch reset when no register is chosen.
// - with latch clearing, the port reset drives both the latch and the output register reset.
// - with only the core register chosen, the embedded primitive register stays disabled.
// - with no register chosen, read data comes straight from the ram output latch.
// - the unregistered arrangement adds no cycles beyond the basic ram read.
// - without latch clearing, a port reset clears the chosen output registers to the init value, or the latch when none is chosen.
// - with latch clearing, a port reset shows the init value on read data for two cycles.
// - a per-port setting picks whether reset or enable wins when reset is active and the enable is not.
`timescale 1ns/10ps
module ram_output_register_stage #(
	parameter int DATA_W = ram_out_pkg::DATA_W,
	parameter int ADDR_W = ram_out_pkg::ADDR_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ram_out_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// port a user side
	input wire logic portARamEnable,
	input wire logic portAOutputRegisterEnable,
	input wire logic portAWriteEnable,
	input wire logic portAReset,
	input wire logic [ADDR_W-1:0] portAAddr,
	input wire logic [DATA_W-1:0] portAWriteData,
	output logic [DATA_W-1:0] portAReadData,
	// port b user side
	input wire logic portBRamEnable,
	input wire logic portBOutputRegisterEnable,
	input wire logic portBWriteEnable,
	input wire logic portBReset,
	input wire logic [ADDR_W-1:0] portBAddr,
	input wire logic [DATA_W-1:0] portBWriteData,
	output logic [DATA_W-1:0] portBReadData
);
	import ram_out_pkg::*;

	localparam int DEPTH = 1 << ADDR_W;

	// ****************************************
	// register file
	// ****************************************
	logic [CFG_W-1:0] cfgA;
	logic [CFG_W-1:0] cfgB;
	logic [DATA_W-1:0] initA;
	logic [DATA_W-1:0] initB;
	logic [31:0] statusQ;
	logic [31:0] statusD;

	apb_cfg_regs regs (
		.clk(clk),
		.reset_n(reset_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.cfgA(cfgA),
		.cfgB(cfgB),
		.initA(initA),
		.initB(initB),
		.statusWord(statusQ)
	);

	// ****************************************
	// per-port gathering
	// ****************************************
	logic [CFG_W-1:0] cfg [NUM_PORTS];
	logic [DATA_W-1:0] initVal [NUM_PORTS];
	logic ramEn [NUM_PORTS];
	logic regEn [NUM_PORTS];
	logic wrEn [NUM_PORTS];
	logic portRst [NUM_PORTS];
	logic [ADDR_W-1:0] addr [NUM_PORTS];
	logic [DATA_W-1:0] wrData [NUM_PORTS];
	logic [DATA_W-1:0] rdData [NUM_PORTS];

	assign cfg[0] = cfgA;
	assign cfg[1] = cfgB;
	assign initVal[0] = initA;
	assign initVal[1] = initB;
	assign ramEn[0] = portARamEnable;
	assign ramEn[1] = portBRamEnable;
	assign regEn[0] = portAOutputRegisterEnable;
	assign regEn[1] = portBOutputRegisterEnable;
	assign wrEn[0] = portAWriteEnable;
	assign wrEn[1] = portBWriteEnable;
	assign portRst[0] = portAReset;
	assign portRst[1] = portBReset;
	assign addr[0] = portAAddr;
	assign addr[1] = portBAddr;
	assign wrData[0] = portAWriteData;
	assign wrData[1] = portBWriteData;
	assign portAReadData = rdData[0];
	assign portBReadData = rdData[1];

	// ****************************************
	// memory array
	// ****************************************
	logic [DATA_W-1:0] mem [DEPTH];

	// same-address collision: port b's write lands last and wins
	always_ff @(posedge clk) begin
		if (ramEn[0] && wrEn[0]) begin
			mem[addr[0]] <= wrData[0];
		end
		if (ramEn[1] && wrEn[1]) begin
			mem[addr[1]] <= wrData[1];
		end
	end

	// ****************************************
	// output pipeline per port
	// ****************************************
	logic primOn [NUM_PORTS];
	logic coreOn [NUM_PORTS];
	logic rstOn [NUM_PORTS];
	logic latchClrOn [NUM_PORTS];
	logic registered [NUM_PORTS];
	logic gateEn [NUM_PORTS];
	logic doReset [NUM_PORTS];
	logic [1:0] latency [NUM_PORTS];

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : gPort
			logic [DATA_W-1:0] latchQ;
			logic [DATA_W-1:0] primQ;
			logic [DATA_W-1:0] coreQ;
			logic [DATA_W-1:0] coreIn;

			// settings come from this port's own register only
			assign primOn[p] = cfg[p][CFG_PRIM_BIT];
			assign coreOn[p] = cfg[p][CFG_CORE_BIT];
			assign rstOn[p] = cfg[p][CFG_RSTEN_BIT];
			// option is ignored outside the primitive-only arrangement
			assign latchClrOn[p] = cfg[p][CFG_LATCHCLR_BIT] & primOn[p] & ~coreOn[p]
				& rstOn[p];
			assign registered[p] = primOn[p] | coreOn[p];
			// enable that competes with reset depends on arrangement
			assign gateEn[p] = registered[p] ? regEn[p] : ramEn[p];
			assign doReset[p] = rstOn[p] & portRst[p]
				& (cfg[p][CFG_RSTWIN_BIT] | gateEn[p]);

			// ram output latch: read-first, one cycle after the enable
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					latchQ <= INIT_RESET;
				end else if (doReset[p] && (latchClrOn[p] || !registered[p])) begin
					latchQ <= initVal[p];
				end else if (ramEn[p]) begin
					latchQ <= mem[addr[p]];
				end
			end

			// embedded primitive register; frozen while not chosen
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					primQ <= INIT_RESET;
				end else if (!primOn[p]) begin
					primQ <= primQ;
				end else if (doReset[p]) begin
					primQ <= initVal[p];
				end else if (regEn[p]) begin
					primQ <= latchQ;
				end
			end

			// second stage is fed from the first when both are on
			assign coreIn = primOn[p] ? primQ : latchQ;

			always_ff @(posedge clk) begin
				if (!reset_n) begin
					coreQ <= INIT_RESET;
				end else if (!coreOn[p]) begin
					coreQ <= coreQ;
				end else if (doReset[p]) begin
					coreQ <= initVal[p];
				end else if (regEn[p]) begin
					coreQ <= coreIn;
				end
			end

			// every source is a flop; the select only picks the last stage
			assign rdData[p] = coreOn[p] ? coreQ : (primOn[p] ? primQ : latchQ);
			assign latency[p] = {1'b0, primOn[p]} + {1'b0, coreOn[p]};
		end
	endgenerate

	// ****************************************
	// status
	// ****************************************
	always_comb begin
		statusD = STATUS_RESET;
		for (int i = 0; i < NUM_PORTS; i++) begin
			statusD[i*STAT_STRIDE+STAT_LAT_LSB +: 2] = latency[i];
			statusD[i*STAT_STRIDE+STAT_LATCHCLR_BIT] = latchClrOn[i];
			statusD[i*STAT_STRIDE+STAT_REGISTERED_BIT] = registered[i];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			statusQ <= STATUS_RESET;
		end else begin
			statusQ <= statusD;
		end
	end

endmodule

// [verif/ram_out_chk.sv]
`timescale 1ns/10ps
module ram_out_chk (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ram_out_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// port a
	input wire logic portARamEnable,
	input wire logic portAOutputRegisterEnable,
	input wire logic portAWriteEnable,
	input wire logic portAReset,
	input wire logic [ram_out_pkg::ADDR_W-1:0] portAAddr,
	input wire logic [ram_out_pkg::DATA_W-1:0] portAWriteData,
	input wire logic [ram_out_pkg::DATA_W-1:0] portAReadData
);
	import ram_out_pkg::*;
	logic [CFG_W-1:0] cA;
	logic [DATA_W-1:0] iA, lA;
	logic [DATA_W-1:0] mA [2**ADDR_W];
	wire logic wrOk = psel && penable && pready && pwrite;
	wire logic [DATA_W-1:0] rA = mA[portAAddr];
	wire logic en = portARamEnable;
	wire logic re = portAOutputRegisterEnable;
	wire logic rs = portAReset;
	wire logic rd = en && !portAWriteEnable && !rs;
	wire logic [DATA_W-1:0] q = portAReadData;
	// ****
	// shadows; port b writes are not tracked, so a must not read b's words
	// ****
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cA <= CFG_RESET;
			iA <= INIT_RESET;
		end else if (wrOk && paddr == OFF_CFG_A) begin
			cA <= pwdata[CFG_W-1:0];
		end else if (wrOk && paddr == OFF_INIT_A) begin
			iA <= pwdata;
		end
	end
	always_ff @(posedge clk) begin
		if (en && portAWriteEnable) begin
			mA[portAAddr] <= portAWriteData;
		end
		if (en) begin
			lA <= rA;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_APB_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("apb answer not after one wait");
	AST_APB_ERR: assert property (pready && paddr > OFF_STATUS |-> pslverr)
		else $error("unmapped address without error");
	AST_NOREG_LAT: assert property (cA[1:0] == 2'b00 && rd |=> q == $past(rA))
		else $error("unregistered read data wrong");
	AST_ONEREG_LAT: assert property ((cA[0] ^ cA[1]) && rd ##1 re && !rs |=> q == $past(rA, 2))
		else $error("single stage read data wrong");
	AST_TWOREG_LAT: assert property (&cA[1:0] && rd ##1 (re && !rs) [*2] |=> q == $past(rA, 3))
		else $error("two stage read data wrong");
	AST_LATCH_CLR: assert property (cA == 5'h1d && rs |=> (q == iA) [*2])
		else $error("latch clear not two cycles");
	AST_REG_CLR: assert property (cA == 5'h15 && rs ##1 !rs && re |-> q == iA ##1 q == $past(lA))
		else $error("latch not kept");
	AST_EN_WINS: assert property (cA == 5'h04 && rs && !en |=> $stable(q))
		else $error("reset acted without enable");
	AST_REG_GATE: assert property (cA == 5'h05 && rs && !re |=> $stable(q))
		else $error("register reset acted without register enable");
	COV_CLR: cover property (cA == 5'h1d && rs);
	COV_TWO: cover property (&cA[1:0] && rd);
	COV_ERR: cover property (pready && pslverr);
endmodule
bind ram_output_register_stage ram_out_chk chk (.clk(clk), .reset_n(reset_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .portARamEnable(portARamEnable),
	.portAOutputRegisterEnable(portAOutputRegisterEnable),
	.portAWriteEnable(portAWriteEnable), .portAReset(portAReset), .portAAddr(portAAddr),
	.portAWriteData(portAWriteData), .portAReadData(portAReadData));

// [verif/user_port.sv]
`timescale 1ns/10ps
module user_port (
	// clock and read data
	input wire logic clk,
	input wire logic [ram_out_pkg::DATA_W-1:0] q,
	// port controls
	output logic en,
	output logic re,
	output logic we,
	output logic rs,
	output logic [ram_out_pkg::ADDR_W-1:0] a,
	output logic [ram_out_pkg::DATA_W-1:0] d
);
	import ram_out_pkg::*;
	// register enable idles high; hold lowers it for the gating tests
	initial begin
		en = 0;
		re = 1;
		we = 0;
		rs = 0;
		a = '0;
		d = '0;
	end
	task automatic op(input logic e, w, r, input logic [9:0] ad, input logic [31:0] dt);
		@(posedge clk);
		en <= e;
		we <= w;
		rs <= r;
		a <= ad;
		d <= dt;
	endtask
	task automatic hold(input logic r);
		@(posedge clk);
		re <= r;
	endtask
	task automatic wr(input logic [9:0] ad, input logic [31:0] dt);
		op(1, 1, 0, ad, dt);
		op(0, 0, 0, ad, ~dt);
	endtask
	// samples just before and just after the last stage loads
	task automatic rd(input logic [9:0] ad, input int n, output logic [31:0] old, nw);
		op(1, 0, 0, ad, '0);
		repeat (n) op(0, 0, 0, ad, '1);
		#1 old = q;
		op(0, 0, 0, ad, '1);
		#1 nw = q;
	endtask
endmodule

// [verif/tb.sv]
`timescale 1ns/10ps
module tb;
	import ram_out_pkg::*;
	logic clk = 0;
	logic reset_n = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, qA, qB, v, o, w;
	logic pready, pslverr, e;
	logic enA, reA, weA, rsA, enB, reB, weB, rsB;
	logic [9:0] aA, aB;
	logic [31:0] dA, dB;
	int badCount = 0;
	int nChecks = 0;
	int cyc = 0;
	logic [4:0] rowCfg [4] = '{5'h04, 5'h05, 5'h06, 5'h07};
	int rowLat [4] = '{0, 1, 1, 2};
	always #2 clk = ~clk;
	ram_output_register_stage dut (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.portARamEnable(enA), .portAOutputRegisterEnable(reA), .portAWriteEnable(weA),
		.portAReset(rsA), .portAAddr(aA), .portAWriteData(dA), .portAReadData(qA),
		.portBRamEnable(enB), .portBOutputRegisterEnable(reB), .portBWriteEnable(weB),
		.portBReset(rsB), .portBAddr(aB), .portBWriteData(dB), .portBReadData(qB));
	user_port uA (.clk(clk), .q(qA), .en(enA), .re(reA), .we(weA), .rs(rsA), .a(aA), .d(dA));
	user_port uB (.clk(clk), .q(qB), .en(enB), .re(reB), .we(weB), .rs(rsB), .a(aB), .d(dB));
	function automatic logic [7:0] ex(input int n);
		return {4'h0, n != 0, 1'b0, 2'(n)};
	endfunction
	task automatic chk(input string s, input logic [31:0] x, g);
		nChecks++;
		if (g !== x) begin
			badCount++;
			$display("BAD %s expected %h seen %h", s, x, g);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		v = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic pulse(input logic en);
		uA.op(en, 0, 1, 10'h2, '0);
		uA.op(0, 0, 0, 10'h2, '0);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// a run needs a few hundred cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			badCount++;
			summarize();
		end
	end
	// ****
	// sequence
	// ****
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1;
		for (int i = 0; i < 4; i++) begin
			apb(1, OFF_CFG_A, {27'h0, rowCfg[i]});
			apb(1, OFF_CFG_B, {27'h0, rowCfg[3 - i]});
			uA.wr(10'h1, {8'ha1, 19'h0, rowCfg[i]});
			uA.wr(10'h2, {8'ha2, 19'h0, rowCfg[i]});
			uB.wr(10'h3, {8'hb1, 19'h0, rowCfg[i]});
			uB.wr(10'h4, {8'hb2, 19'h0, rowCfg[i]});
			uA.rd(10'h1, rowLat[i], o, w);
			uA.rd(10'h2, rowLat[i], o, w);
			chk("a early", {8'ha1, 19'h0, rowCfg[i]}, o);
			chk("a data", {8'ha2, 19'h0, rowCfg[i]}, w);
			uB.rd(10'h3, rowLat[3 - i], o, w);
			uB.rd(10'h4, rowLat[3 - i], o, w);
			chk("b early", {8'hb1, 19'h0, rowCfg[i]}, o);
			chk("b data", {8'hb2, 19'h0, rowCfg[i]}, w);
			apb(0, OFF_STATUS, '0);
			chk("status", {16'h0, ex(rowLat[3 - i]), ex(rowLat[i])}, v);
			$display("row %0d done", i);
		end
		apb(1, OFF_INIT_A, 32'h5a5a_0001);
		apb(1, OFF_CFG_A, 32'h1d);
		apb(0, OFF_STATUS, '0);
		chk("clear on", 32'h0d, v);
		uA.rd(10'h2, 1, o, w);
		pulse(0);
		#1 chk("clear c1", 32'h5a5a_0001, qA);
		@(posedge clk);
		#1 chk("clear c2", 32'h5a5a_0001, qA);
		apb(1, OFF_CFG_A, 32'h15);
		uA.rd(10'h1, 1, o, w);
		pulse(0);
		#1 chk("reg c1", 32'h5a5a_0001, qA);
		@(posedge clk);
		#1 chk("latch kept", 32'ha100_0007, qA);
		$display("reset kinds done");
		apb(1, OFF_CFG_A, 32'h04);
		uA.rd(10'h2, 0, o, w);
		pulse(0);
		#1 chk("no gate", 32'ha200_0007, qA);
		pulse(1);
		#1 chk("gated", 32'h5a5a_0001, qA);
		apb(1, OFF_CFG_A, 32'h14);
		uA.rd(10'h2, 0, o, w);
		pulse(0);
		#1 chk("reset wins", 32'h5a5a_0001, qA);
		apb(1, OFF_CFG_A, 32'h05);
		uA.rd(10'h1, 1, o, w);
		uA.hold(0);
		pulse(0);
		#1 chk("reg gated", 32'ha100_0007, qA);
		uA.hold(1);
		pulse(0);
		#1 chk("reg reset", 32'h5a5a_0001, qA);
		$display("priority done");
		apb(1, OFF_CFG_A, 32'h0f);
		apb(1, OFF_STATUS, '1);
		apb(0, OFF_STATUS, '0);
		chk("clear off", 32'h0a, v);
		apb(0, 8'h14, '0);
		chk("err", 32'h1, {31'h0, e});
		chk("err data", 32'h0, v);
		$display("bus done");
		reset_n <= 0;
		repeat (2) @(posedge clk);
		reset_n <= 1;
		#1 chk("out reset", 32'h0, qA);
		apb(0, OFF_CFG_A, '0);
		chk("cfg reset", {27'h0, CFG_RESET}, v);
		apb(0, OFF_INIT_A, '0);
		chk("init reset", INIT_RESET, v);
		$display("reset done");
		summarize();
	end
endmodule
